// [hw/awt_pkg.sv]
// Constants and types shared by the autowake and watchdog status block
package awt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_WDT_RESTART = 16'h00f8;
  localparam logic [15:0] IDX_WDT_OVF = 16'h2002;
  localparam logic [15:0] IDX_WAKE_CTL = 16'h20a9;
  localparam logic [15:0] IDX_WDT_FLAG = 16'h20b1;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h2100;
  localparam logic [15:0] IDX_IRQ_CLR = 16'h2101;
  localparam logic [15:0] IDX_IRQ_EN = 16'h2102;
  localparam int ADDR_W = 18;

  // Field positions
  localparam int AW_ARM_BIT = 7;
  localparam int AW_RES_BIT = 3;
  localparam int AW_PERIOD_LSB = 0;
  localparam int PRD_W = 3;
  localparam int WDT_RESTART_BIT = 7;
  localparam int WDT_OVF_BIT = 2;
  localparam int WDT_FLAG_BIT = 0;

  // Interrupt event bits
  localparam int EV_NEAR = 0;
  localparam int EV_OVF = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_N = 3;

  // Values after reset
  localparam logic [PRD_W-1:0] PRD_RST = 3'h1;
  localparam logic RES_RST = 1'h0;
  localparam logic [EV_N-1:0] IRQ_EN_RST = 3'h0;

  // Clock and times
  localparam int CLK_HZ = 100_000_000;
  localparam int NEAR_OVF_US = 1000;
  localparam int NEAR_OVF_CYC = NEAR_OVF_US * (CLK_HZ / 1_000_000);
  localparam int WDT_TIMEOUT_MS = 1500;
  localparam int WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int RTC_HZ = 32768;
  localparam int RES_FINE_MS = 2500;
  localparam int RES_COARSE_S = 60;
  localparam int RES_FINE_TICKS = RES_FINE_MS * RTC_HZ / 1000;
  localparam int RES_COARSE_TICKS = RES_COARSE_S * RTC_HZ;
  localparam int AW_W = 24;

  // Processor power modes
  typedef enum logic [1:0] {
    AWT_FULL_RUN,
    AWT_LOW_SUPPLY,
    AWT_DEEP_SLEEP,
    AWT_DISPLAY_ONLY
  } awt_mode_e;

endpackage : awt_pkg

// [hw/awt_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module awt_pin_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;
  logic [W-1:0] next_level;

  // Level moves only when stages two and three agree
  assign agree = ~(s2 ^ s3);
  assign next_level = (agree & s3) | (~agree & level);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
      rise <= '0;
      fall <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      rise <= next_level & ~level;
      fall <= ~next_level & level;
    end
  end

endmodule : awt_pin_sync

// [hw/awt_top.sv]
// Autowake timer and watchdog status logic with APB register access
//
// How it works
// - Arm write loads autowake duration, arms timer
// - Autowake held while full-run or low-supply
// - Resolution one is minute, zero 2.5 s
// - Near-overflow flag 1 ms early; clears
// - Restart bit byte-wide; 0 clears, 1 restarts
// - Overflow sets status; lost in deep sleep
// - Overflow status cleared while reset pin high
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module awt_top
  import awt_pkg::*;
#(
  parameter int WDT_CYC = WDT_TIMEOUT_CYC,
  parameter int NEAR_CYC = NEAR_OVF_CYC,
  parameter int FINE_TICKS = RES_FINE_TICKS,
  parameter int COARSE_TICKS = RES_COARSE_TICKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire awt_mode_e power_mode,
  input wire logic rtc_clk_pin,
  input wire logic wake_pin,
  input wire logic reset_pin,
  output logic wake_event,
  output logic watchdog_reset,
  output logic irq
);

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // Autowake duration in RTC ticks
  function automatic logic [AW_W-1:0] duration(
    input logic [PRD_W-1:0] prd,
    input logic res
  );
    logic [AW_W-1:0] unit;
    unit = res ? AW_W'(COARSE_TICKS) : AW_W'(FINE_TICKS);
    duration = AW_W'(prd * unit);
  endfunction : duration

  localparam logic [31:0] WDT_LAST = 32'(WDT_CYC - 1);
  localparam logic [31:0] WDT_NEAR_AT = 32'(WDT_CYC - 1 - NEAR_CYC);

  // Pin synchronisers
  logic [2:0] pin_in;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_in = {rtc_clk_pin, wake_pin, reset_pin};

  awt_pin_sync #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin(pin_in),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic reset_high;
  logic wake_fall;
  logic rtc_tick;

  assign reset_high = pin_level[0];
  assign wake_fall = pin_fall[1];
  assign rtc_tick = pin_rise[2];

  // APB decode
  logic setup;
  logic access;
  logic wr;
  logic hit_restart;
  logic hit_ovf;
  logic hit_wake;
  logic hit_flag;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic mapped;
  logic lane0;
  logic lane0_only;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign hit_restart = paddr == byte_addr(IDX_WDT_RESTART);
  assign hit_ovf = paddr == byte_addr(IDX_WDT_OVF);
  assign hit_wake = paddr == byte_addr(IDX_WAKE_CTL);
  assign hit_flag = paddr == byte_addr(IDX_WDT_FLAG);
  assign hit_stat = paddr == byte_addr(IDX_IRQ_STAT);
  assign hit_clr = paddr == byte_addr(IDX_IRQ_CLR);
  assign hit_en = paddr == byte_addr(IDX_IRQ_EN);
  assign mapped = hit_restart | hit_ovf | hit_wake | hit_flag
                | hit_stat | hit_clr | hit_en;
  assign lane0 = pstrb[0];
  assign lane0_only = pstrb == 4'h1;

  // Zero-wait slave; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Register write strobes
  logic wr_restart;
  logic wr_ovf;
  logic wr_wake;
  logic wr_flag;
  logic wr_clr;
  logic wr_en;
  logic wdt_restart;
  logic flag_clear_sw;
  logic aw_arm;

  assign wr_restart = wr & hit_restart & lane0_only;
  assign wr_ovf = wr & hit_ovf & lane0;
  assign wr_wake = wr & hit_wake & lane0;
  assign wr_flag = wr & hit_flag & lane0;
  assign wr_clr = wr & hit_clr & lane0;
  assign wr_en = wr & hit_en & lane0;
  assign wdt_restart = wr_restart & pwdata[WDT_RESTART_BIT];
  assign flag_clear_sw = (wr_restart & ~pwdata[WDT_RESTART_BIT])
                       | (wr_flag & ~pwdata[WDT_FLAG_BIT]);
  assign aw_arm = wr_wake & pwdata[AW_ARM_BIT];

  // Mode decode
  logic aw_hold;
  logic aw_run;
  logic in_deep_sleep;

  assign aw_hold = (power_mode == AWT_FULL_RUN)
                 | (power_mode == AWT_LOW_SUPPLY);
  assign aw_run = ~aw_hold;
  assign in_deep_sleep = power_mode == AWT_DEEP_SLEEP;

  // Watchdog counter
  logic [31:0] wdt_cnt;
  logic wdt_last;
  logic wdt_near;

  assign wdt_last = wdt_cnt == WDT_LAST;
  assign wdt_near = wdt_cnt == WDT_NEAR_AT;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt <= 32'h0000_0000;
    end else if (wdt_restart || wdt_last) begin
      wdt_cnt <= 32'h0000_0000;
    end else begin
      wdt_cnt <= wdt_cnt + 32'h0000_0001;
    end
  end

  // Overflow pulse to the processor reset logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wdt_last & ~wdt_restart;
    end
  end

  logic wdt_ovf_ev;

  assign wdt_ovf_ev = wdt_last & ~wdt_restart;

  // Near-overflow flag, set wins over any clear
  logic near_flag;
  logic next_near_flag;

  assign next_near_flag = wdt_near | (near_flag & ~flag_clear_sw & ~wake_fall);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      near_flag <= 1'b0;
    end else begin
      near_flag <= next_near_flag;
    end
  end

  // Overflow status
  logic ovf_status;
  logic next_ovf_status;
  logic ovf_kept;

  assign ovf_kept = wr_ovf ? pwdata[WDT_OVF_BIT] : ovf_status;
  assign next_ovf_status = reset_high ? 1'b0
                         : wdt_ovf_ev ? 1'b1
                         : in_deep_sleep ? 1'b0
                         : ovf_kept;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_status <= 1'b0;
    end else begin
      ovf_status <= next_ovf_status;
    end
  end

  // Autowake settings
  logic [PRD_W-1:0] aw_period;
  logic aw_res;
  logic [PRD_W-1:0] next_period;
  logic next_res;

  assign next_period = pwdata[AW_PERIOD_LSB +: PRD_W];
  assign next_res = pwdata[AW_RES_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_period <= PRD_RST;
      aw_res <= RES_RST;
    end else if (wr_wake) begin
      aw_period <= next_period;
      aw_res <= next_res;
    end
  end

  // Autowake countdown in RTC ticks
  logic aw_armed;
  logic [AW_W-1:0] aw_cnt;
  logic aw_step;
  logic aw_expire;
  logic [AW_W-1:0] aw_load;

  assign aw_load = duration(next_period, next_res);
  assign aw_step = aw_armed & aw_run & rtc_tick & ~aw_arm;
  assign aw_expire = aw_step & (aw_cnt <= 24'h00_0001);

  // Arm loads now; firmware leaves three RTC ticks before sleep
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_armed <= 1'b0;
      aw_cnt <= 24'h00_0000;
    end else if (aw_arm) begin
      aw_armed <= 1'b1;
      aw_cnt <= aw_load;
    end else if (aw_expire) begin
      aw_armed <= 1'b0;
      aw_cnt <= 24'h00_0000;
    end else if (aw_step) begin
      aw_cnt <= aw_cnt - 24'h00_0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= aw_expire;
    end
  end

  // Interrupt status, enable and clear
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] irq_stat;
  logic [EV_N-1:0] irq_en;
  logic [EV_N-1:0] irq_clr;
  logic [EV_N-1:0] next_irq_stat;

  assign ev[EV_NEAR] = wdt_near;
  assign ev[EV_OVF] = wdt_ovf_ev;
  assign ev[EV_WAKE] = aw_expire;
  assign irq_clr = wr_clr ? pwdata[EV_N-1:0] : '0;
  assign next_irq_stat = ev | (irq_stat & ~irq_clr);

  logic irq_level;

  assign irq_level = |(next_irq_stat & irq_en);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Enable register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_en <= IRQ_EN_RST;
    end else if (wr_en) begin
      irq_en <= pwdata[EV_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_level;
    end
  end

  // Read data, captured in the setup cycle
  logic [31:0] rd_ovf;
  logic [31:0] rd_wake;
  logic [31:0] rd_flag;
  logic [31:0] rd_stat;
  logic [31:0] rd_en;
  logic [31:0] next_prdata;
  logic rd_capture;

  assign rd_ovf = 32'(ovf_status) << WDT_OVF_BIT;
  assign rd_wake = (32'(aw_res) << AW_RES_BIT)
                 | (32'(aw_period) << AW_PERIOD_LSB);
  assign rd_flag = 32'(near_flag) << WDT_FLAG_BIT;
  assign rd_stat = 32'(irq_stat);
  assign rd_en = 32'(irq_en);
  assign next_prdata = hit_ovf ? rd_ovf
                     : hit_wake ? rd_wake
                     : hit_flag ? rd_flag
                     : hit_stat ? rd_stat
                     : hit_en ? rd_en
                     : 32'h0000_0000;
  assign rd_capture = setup & ~pwrite;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_capture) begin
      prdata <= next_prdata;
    end
  end

endmodule : awt_top

// [sim/awt_top_chk.sv]
// Assertion checker for the autowake and watchdog status block
`timescale 1ns/10ps
module awt_top_chk
  import awt_pkg::*;
#(
  parameter int WDT_CYC = 400
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire awt_mode_e power_mode,
  input wire logic wake_event,
  input wire logic watchdog_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic hit = paddr inside {18'h0_03e0, 18'h0_8008, 18'h0_82a4, 18'h0_82c4,
    18'h0_8400, 18'h0_8404, 18'h0_8408};
  wire logic kick = acc && pwrite && paddr == 18'h0_03e0 && pstrb == 4'h1 && pwdata[7];
  logic [31:0] since;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since <= '0;
    else if (kick || watchdog_reset) since <= '0;
    else since <= since + 32'h0000_0001;
  end
  sequence s_quiet;
    !watchdog_reset [*8];
  endsequence
  a_wdt_early: assert property (watchdog_reset |-> since >= WDT_CYC - 3)
    else $error("watchdog pulse too early");
  a_wdt_late: assert property (since <= WDT_CYC + 2)
    else $error("watchdog pulse missing");
  a_wdt_pulse: assert property (watchdog_reset |=> s_quiet)
    else $error("watchdog pulse too long");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  a_wake_mode: assert property (wake_event |->
    $past(power_mode) inside {AWT_DEEP_SLEEP, AWT_DISPLAY_ONLY})
    else $error("wake outside sleep");
  a_err_unmapped: assert property (rd && !hit |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
  a_err_mapped: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  a_rd_upper: assert property (rd |-> prdata[31:8] == '0)
    else $error("upper read bits set");
  a_arm_wo: assert property (rd && paddr == 18'h0_82a4 |-> !prdata[7])
    else $error("arm bit readable");
  a_restart_wo: assert property (rd && paddr == 18'h0_03e0 |-> prdata == '0)
    else $error("restart readable");
endmodule : awt_top_chk

bind awt_top awt_top_chk #(.WDT_CYC(WDT_CYC)) u_chk (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_mode(power_mode), .wake_event(wake_event), .watchdog_reset(watchdog_reset));

// [sim/awt_top_bench.sv]
// Testbench for the autowake and watchdog status block
`timescale 1ns/10ps
module awt_top_bench;
  import awt_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, last_err;
  logic rtc_clk_pin, wake_pin, reset_pin, wake_event, watchdog_reset, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  awt_mode_e power_mode;
  int err_total, comparisons, wakes, wres;

  awt_top #(.WDT_CYC(400), .NEAR_CYC(50), .FINE_TICKS(4), .COARSE_TICKS(10)) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
    .rtc_clk_pin(rtc_clk_pin), .wake_pin(wake_pin), .reset_pin(reset_pin),
    .wake_event(wake_event), .watchdog_reset(watchdog_reset), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wake_event === 1'b1) wakes++;
    if (watchdog_reset === 1'b1) wres++;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    pstrb <= 4'h1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, idx, d, r);
  endtask : wr

  task automatic chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, idx, 32'h0000_0000, r);
    cmp(r, exp);
  endtask : chk

  task automatic tick(input int n);
    repeat (n) begin
      rtc_clk_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rtc_clk_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : tick

  task automatic tally_and_finish();
    $display("counts: %0d compared, %0d failed", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100_000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, rtc_clk_pin, wake_pin, reset_pin} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    power_mode = AWT_FULL_RUN;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    chk(IDX_WAKE_CTL, 32'h0000_0001);
    chk(IDX_WDT_OVF, 32'h0000_0000);
    chk(IDX_IRQ_EN, 32'h0000_0000);
    chk(16'h3000, 32'h0000_0000);
    cmp(32'(last_err), 32'h0000_0001);
    $display("test reset done");
    repeat (4) begin
      repeat (250) @(posedge clk);
      wr(IDX_WDT_RESTART, 32'h0000_0080);
    end
    cmp(wres, 0);
    repeat (420) @(posedge clk);
    cmp(wres, 1);
    chk(IDX_WDT_OVF, 32'h0000_0004);
    chk(IDX_IRQ_STAT, 32'h0000_0003);
    cmp(32'(irq), 32'h0000_0000);
    wr(IDX_IRQ_EN, 32'h0000_0002);
    chk(IDX_IRQ_EN, 32'h0000_0002);
    cmp(32'(irq), 32'h0000_0001);
    wr(IDX_IRQ_CLR, 32'h0000_0002);
    chk(IDX_IRQ_STAT, 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000);
    reset_pin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(IDX_WDT_OVF, 32'h0000_0000);
    reset_pin <= 1'b0;
    repeat (8) @(posedge clk);
    wr(IDX_WDT_OVF, 32'h0000_0004);
    chk(IDX_WDT_OVF, 32'h0000_0004);
    $display("test watchdog done");
    for (int k = 0; k < 3; k++) begin
      wr(IDX_WDT_RESTART, 32'h0000_0080);
      repeat (360) @(posedge clk);
      chk(IDX_WDT_FLAG, 32'h0000_0001);
      if (k == 0) begin
        wr(IDX_WDT_FLAG, 32'h0000_0000);
      end else if (k == 1) begin
        wr(IDX_WDT_RESTART, 32'h0000_0000);
      end else begin
        wake_pin <= 1'b1;
        repeat (8) @(posedge clk);
        wake_pin <= 1'b0;
        repeat (8) @(posedge clk);
      end
      chk(IDX_WDT_FLAG, 32'h0000_0000);
    end
    $display("test near flag done");
    for (int k = 0; k < 2; k++) begin
      power_mode <= k ? AWT_LOW_SUPPLY : AWT_FULL_RUN;
      wr(IDX_WDT_OVF, 32'h0000_0004);
      wr(IDX_WAKE_CTL, k ? 32'h0000_008a : 32'h0000_0083);
      chk(IDX_WAKE_CTL, k ? 32'h0000_000a : 32'h0000_0003);
      tick(3);
      cmp(wakes, k);
      power_mode <= k ? AWT_DISPLAY_ONLY : AWT_DEEP_SLEEP;
      tick(k ? 19 : 11);
      cmp(wakes, k);
      if (k == 0) chk(IDX_WDT_OVF, 32'h0000_0000);
      tick(1);
      cmp(wakes, k + 1);
    end
    $display("test autowake done");
    tally_and_finish();
  end
endmodule : awt_top_bench
